// ### core/nfctw_axil.v
/*
 AXI4-Lite slave front end: one write and one read in flight, decoded into
 single-cycle register strobes on a word index.
 Assumes the register core answers read data and decode combinationally.
*/
`timescale 1ns/1ps
`include "nfctw_map.vh"
module nfctw_axil (
   // Clock and reset
   input wire i_ref_clk,
   input wire i_arst_n,
   // Write address and data
   input wire [7:0] i_awaddr,
   input wire i_awvalid,
   output reg o_awready,
   input wire [31:0] i_wdata,
   input wire [3:0] i_wstrb,
   input wire i_wvalid,
   output reg o_wready,
   output reg [1:0] o_bresp,
   output reg o_bvalid,
   input wire i_bready,
   // Read address and data
   input wire [7:0] i_araddr,
   input wire i_arvalid,
   output reg o_arready,
   output reg [31:0] o_rdata,
   output reg [1:0] o_rresp,
   output reg o_rvalid,
   input wire i_rready,
   // Register strobes
   output reg o_wr_en,
   output reg [5:0] o_wr_idx,
   output reg [7:0] o_wr_data,
   output reg o_rd_en,
   output reg [5:0] o_rd_idx,
   input wire [7:0] i_rd_data,
   input wire i_wr_hit,
   input wire i_rd_hit
);
   reg aw_have_q;
   reg w_have_q;
   reg lane0_q;

   // Write path; address and data may arrive in either order
   always @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         lane0_q <= 1'b0;
         o_awready <= 1'b1;
         o_wready <= 1'b1;
         o_bvalid <= 1'b0;
         o_bresp <= `NFCTW_RESP_OKAY;
         o_wr_en <= 1'b0;
         o_wr_idx <= 6'h00;
         o_wr_data <= 8'h00;
      end else begin
         o_wr_en <= 1'b0;
         if (i_awvalid && o_awready) begin
            aw_have_q <= 1'b1;
            o_awready <= 1'b0;
            o_wr_idx <= i_awaddr[7:2];
         end
         if (i_wvalid && o_wready) begin
            w_have_q <= 1'b1;
            o_wready <= 1'b0;
            o_wr_data <= i_wdata[7:0];
            lane0_q <= i_wstrb[0];
         end
         if (aw_have_q && w_have_q && !o_bvalid) begin
            o_wr_en <= lane0_q;   // Upper lanes hold nothing, so only lane 0 writes
            o_bvalid <= 1'b1;
            o_bresp <= i_wr_hit ? `NFCTW_RESP_OKAY : `NFCTW_RESP_SLVERR;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
         end
         if (o_bvalid && i_bready) begin
            o_bvalid <= 1'b0;
            o_awready <= 1'b1;
            o_wready <= 1'b1;
         end
      end
   end

   // Read path; data captured in the strobe cycle so side effects and data agree
   always @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_arready <= 1'b1;
         o_rd_en <= 1'b0;
         o_rd_idx <= 6'h00;
         o_rvalid <= 1'b0;
         o_rdata <= 32'h0000_0000;
         o_rresp <= `NFCTW_RESP_OKAY;
      end else begin
         o_rd_en <= 1'b0;
         if (i_arvalid && o_arready) begin
            o_arready <= 1'b0;
            o_rd_en <= 1'b1;
            o_rd_idx <= i_araddr[7:2];
         end
         if (o_rd_en) begin
            o_rvalid <= 1'b1;
            o_rdata <= {24'h00_0000, i_rd_data};
            o_rresp <= i_rd_hit ? `NFCTW_RESP_OKAY : `NFCTW_RESP_SLVERR;
         end
         if (o_rvalid && i_rready) begin
            o_rvalid <= 1'b0;
            o_arready <= 1'b1;
         end
      end
   end
endmodule

// ### core/nfctw_core.v
/*
 NFC target wake-up, interrupt handshake, first-command classification and
 mode dispatch, with its register file behind AXI4-Lite.
 Assumes a receive/transmit decoder on the same clock that pulses its events,
 analog comparators and pins that are asynchronous, and a separate power-on
 reset for the always-on rail that keeps the wake configuration.
*/
`timescale 1ns/1ps
`include "nfctw_map.vh"

// Notes on behaviour
// - Supply held by hold-enable; off when both low unless a wake forces enable
// - Nonzero wake code enables RF monitoring
// - RF above threshold forces internal enable
// - Extended-range bit selects high threshold table
// - Wake config survives power-down; rail reset only
// - Auto anticollision runs internal single-device detection
// - Id-size bits choose identifier length
// - Oscillator stable sets flag and field interrupt
// - First command raises receive-start, ends power-up
// - Protocol bits 7,6 show live comparators
// - First command coding type is recorded
// - Bit-rate field 01/10/11, 00 unavailable
// - Protocol info clears off; low bits on read
// - Wake request starts anticollision, clock extractor
// - Field loss interrupts with field-change bit
// - Card emulation for type A and B
// - SENSF request selects passive high rate
// - ATR request makes active target
// - Status clears on read, write, disable
// - Tx/rx flags early, interrupt at end
// - FIFO, CRC, parity, framing, collision, timeout flags
module nfctw_core (
   // Clock and resets
   input wire i_ref_clk,
   input wire i_arst_n,
   input wire i_vext_arst_n,
   // Pins and analog levels (asynchronous)
   input wire i_supply_hold_enable,
   input wire i_chip_enable,
   input wire i_wake_level_comparator,
   input wire i_collision_level_comparator,
   input wire i_osc_stable,
   // Receive and transmit decoder events (same clock)
   input wire i_first_cmd_valid,
   input wire [2:0] i_first_cmd_kind,
   input wire i_first_cmd_high_coding,
   input wire [1:0] i_first_cmd_rate,
   input wire i_tx_start,
   input wire i_tx_done,
   input wire i_rx_sof,
   input wire i_rx_done,
   input wire i_fifo_level,
   input wire i_crc_error,
   input wire i_parity_error,
   input wire i_framing_error,
   input wire i_collision,
   input wire i_no_response,
   // AXI4-Lite slave
   input wire [7:0] i_awaddr,
   input wire i_awvalid,
   output wire o_awready,
   input wire [31:0] i_wdata,
   input wire [3:0] i_wstrb,
   input wire i_wvalid,
   output wire o_wready,
   output wire [1:0] o_bresp,
   output wire o_bvalid,
   input wire i_bready,
   input wire [7:0] i_araddr,
   input wire i_arvalid,
   output wire o_arready,
   output wire [31:0] o_rdata,
   output wire [1:0] o_rresp,
   output wire o_rvalid,
   input wire i_rready,
   // Power and front-end control
   output reg o_supply_on,
   output reg o_internal_enable,
   output reg o_rf_detect_enable,
   output reg [10:0] o_wake_threshold_mv,
   output reg o_clock_extractor_enable,
   output reg o_auto_sdd_enable,
   output reg [1:0] o_id_size,
   output reg [2:0] o_target_mode,
   output reg o_cmd_to_fifo,
   output reg o_irq
);
   localparam ST_OFF = 3'h0;
   localparam ST_SLEEP = 3'h1;
   localparam ST_WAKING = 3'h2;
   localparam ST_WAIT_CMD = 3'h3;
   localparam ST_ACTIVE = 3'h4;
   localparam ST_ABORTED = 3'h5;

   wire [4:0] sync_lv;
   wire hold_en;
   wire chip_en;
   wire wake_cmp;
   wire coll_cmp;
   wire osc_ok;
   wire wr_en;
   wire [5:0] wr_idx;
   wire [7:0] wr_data;
   wire rd_en;
   wire [5:0] rd_idx;
   reg [7:0] rd_data;
   reg [2:0] state_q;
   reg [2:0] state_d;
   reg forced_en_q;
   reg osc_flag_q;
   reg [7:0] target_wake_level_config_q;
   reg [7:0] protocol_control_q;
   reg [7:0] interrupt_cause_status_q;
   reg [4:0] first_command_protocol_info_q;
   reg cmd_latched_q;
   reg irq_q;
   reg [7:0] irq_set;
   reg irq_fire;
   reg clr_status;
   reg [4:0] proto_d;
   reg [2:0] mode_d;

   // Which word indices exist
   function mapped;
      input [5:0] idx;
      begin
         mapped = (idx == `NFCTW_IDX_PROTOCOL_CONTROL) || (idx == `NFCTW_IDX_IRQ_STATUS) ||
            (idx == `NFCTW_IDX_POWER_STATUS) || (idx == `NFCTW_IDX_WAKE_CONFIG) ||
            (idx == `NFCTW_IDX_PROTOCOL_INFO);
      end
   endfunction

   // Wake code to threshold; the code value is b2b1b0 read as binary
   function [10:0] threshold;
      input ext;
      input [2:0] code;
      begin
         case ({ext, code})
            4'h1: threshold = `NFCTW_THR_LO_1;
            4'h2: threshold = `NFCTW_THR_LO_2;
            4'h3: threshold = `NFCTW_THR_LO_3;
            4'h4: threshold = `NFCTW_THR_LO_4;
            4'h5: threshold = `NFCTW_THR_LO_5;
            4'h6: threshold = `NFCTW_THR_LO_6;
            4'h7: threshold = `NFCTW_THR_LO_7;
            4'h9: threshold = `NFCTW_THR_HI_1;
            4'hA: threshold = `NFCTW_THR_HI_2;
            4'hB: threshold = `NFCTW_THR_HI_3;
            4'hC: threshold = `NFCTW_THR_HI_4;
            4'hD: threshold = `NFCTW_THR_HI_5;
            4'hE: threshold = `NFCTW_THR_HI_6;
            4'hF: threshold = `NFCTW_THR_HI_7;
            default: threshold = 11'h000;
         endcase
      end
   endfunction

   // Every pin and analog level passes two flops before use
   nfctw_sync #(
      .W(5)
   ) u_sync (
      .i_ref_clk(i_ref_clk),
      .i_arst_n(i_arst_n),
      .i_async({i_supply_hold_enable, i_chip_enable, i_wake_level_comparator,
         i_collision_level_comparator, i_osc_stable}),
      .o_sync(sync_lv)
   );
   assign hold_en = sync_lv[4];
   assign chip_en = sync_lv[3];
   assign wake_cmp = sync_lv[2];
   assign coll_cmp = sync_lv[1];
   assign osc_ok = sync_lv[0];

   nfctw_axil u_axil (
      .i_ref_clk(i_ref_clk),
      .i_arst_n(i_arst_n),
      .i_awaddr(i_awaddr),
      .i_awvalid(i_awvalid),
      .o_awready(o_awready),
      .i_wdata(i_wdata),
      .i_wstrb(i_wstrb),
      .i_wvalid(i_wvalid),
      .o_wready(o_wready),
      .o_bresp(o_bresp),
      .o_bvalid(o_bvalid),
      .i_bready(i_bready),
      .i_araddr(i_araddr),
      .i_arvalid(i_arvalid),
      .o_arready(o_arready),
      .o_rdata(o_rdata),
      .o_rresp(o_rresp),
      .o_rvalid(o_rvalid),
      .i_rready(i_rready),
      .o_wr_en(wr_en),
      .o_wr_idx(wr_idx),
      .o_wr_data(wr_data),
      .o_rd_en(rd_en),
      .o_rd_idx(rd_idx),
      .i_rd_data(rd_data),
      .i_wr_hit(mapped(wr_idx)),
      .i_rd_hit(mapped(rd_idx))
   );

   // Read mux; live comparator bits need no storage
   always @* begin
      case (rd_idx)
         `NFCTW_IDX_PROTOCOL_CONTROL: rd_data = protocol_control_q;
         `NFCTW_IDX_IRQ_STATUS: rd_data = interrupt_cause_status_q;
         `NFCTW_IDX_POWER_STATUS: rd_data = {1'b0, osc_flag_q, 3'h0, state_q};
         `NFCTW_IDX_WAKE_CONFIG: rd_data = target_wake_level_config_q;
         `NFCTW_IDX_PROTOCOL_INFO: rd_data = {wake_cmp, coll_cmp, 1'b0,
            first_command_protocol_info_q};
         default: rd_data = 8'h00;
      endcase
   end

   // Wake config sits on the always-on rail; chip enable never touches it
   always @(posedge i_ref_clk or negedge i_vext_arst_n) begin
      if (!i_vext_arst_n) begin
         target_wake_level_config_q <= `NFCTW_RST_BYTE;
      end else if (wr_en && wr_idx == `NFCTW_IDX_WAKE_CONFIG) begin
         target_wake_level_config_q <= {wr_data[7:5], 1'b0, wr_data[3:0]};
      end
   end

   // Power state machine
   always @* begin
      state_d = state_q;
      case (state_q)
         ST_OFF: begin
            if (hold_en || chip_en) begin
               state_d = ST_SLEEP;
            end else if (o_rf_detect_enable && wake_cmp) begin
               state_d = ST_WAKING;
            end
         end
         ST_SLEEP: begin
            if (o_rf_detect_enable && wake_cmp && !chip_en) begin
               state_d = ST_WAKING;
            end else if (!hold_en && !chip_en) begin
               state_d = ST_OFF;
            end
         end
         ST_WAKING: begin
            if (!wake_cmp) begin
               state_d = ST_ABORTED;
            end else if (osc_ok) begin
               state_d = ST_WAIT_CMD;
            end
         end
         ST_WAIT_CMD: begin
            if (!wake_cmp) begin
               state_d = ST_ABORTED;
            end else if (i_first_cmd_valid) begin
               state_d = ST_ACTIVE;
            end
         end
         ST_ACTIVE: begin
            if (!wake_cmp) begin
               state_d = ST_ABORTED;
            end else if (!chip_en) begin
               state_d = hold_en ? ST_SLEEP : ST_OFF;   // Host never confirmed
            end
         end
         ST_ABORTED: begin
            // Stays until the host drops enable, which resets the procedure
            if (!chip_en) begin
               state_d = hold_en ? ST_SLEEP : ST_OFF;
            end
         end
         default: state_d = ST_OFF;
      endcase
   end

   // Interrupt events; start flags set early, the line waits for the end
   always @* begin
      irq_set = 8'h00;
      irq_fire = 1'b0;
      irq_set[`NFCTW_IRQ_TX] = i_tx_start;
      irq_set[`NFCTW_IRQ_RX_START] = i_rx_sof || (state_q == ST_WAIT_CMD && i_first_cmd_valid);
      irq_set[`NFCTW_IRQ_FIFO] = i_fifo_level;
      irq_set[`NFCTW_IRQ_CRC] = i_crc_error && !protocol_control_q[`NFCTW_CTL_NO_RX_CRC];
      irq_set[`NFCTW_IRQ_PARITY] = i_parity_error;
      irq_set[`NFCTW_IRQ_FRAMING] = i_framing_error;
      irq_set[`NFCTW_IRQ_COLLISION] = i_collision;
      irq_set[`NFCTW_IRQ_NO_RESP] = i_no_response;
      if (state_q == ST_WAKING && state_d == ST_WAIT_CMD) begin
         irq_set[`NFCTW_IRQ_FIELD] = 1'b1;
      end
      if (state_d == ST_ABORTED && state_q != ST_ABORTED) begin
         irq_set[`NFCTW_IRQ_FIELD] = 1'b1;
      end
      irq_fire = (|irq_set[5:0]) || i_tx_done || i_rx_done ||
         (state_q == ST_WAIT_CMD && i_first_cmd_valid);
   end

   // Status clear: effective enable low, control write, or the strobe cycle of a status read
   always @* begin
      clr_status = !(chip_en || forced_en_q) ||
         (wr_en && wr_idx == `NFCTW_IDX_PROTOCOL_CONTROL) ||
         (rd_en && rd_idx == `NFCTW_IDX_IRQ_STATUS);
   end

   // First command classification and dispatch
   always @* begin
      proto_d = 5'h00;
      mode_d = `NFCTW_MODE_NONE;
      proto_d[`NFCTW_PI_HIGH_CODING] = i_first_cmd_high_coding;
      proto_d[`NFCTW_PI_PASSIVE_LOW] = (i_first_cmd_kind == `NFCTW_CMD_SENS);
      proto_d[`NFCTW_PI_TYPE_B] = (i_first_cmd_kind == `NFCTW_CMD_TYPE_B);
      proto_d[1:0] = i_first_cmd_rate;
      case (i_first_cmd_kind)
         `NFCTW_CMD_SENS: begin
            if (protocol_control_q[`NFCTW_CTL_CARD_EMU]) begin
               mode_d = `NFCTW_MODE_CARD_A;
            end else if (target_wake_level_config_q[`NFCTW_AUTO_SDD]) begin
               mode_d = `NFCTW_MODE_SDD_AUTO;
            end else begin
               mode_d = `NFCTW_MODE_SDD_HOST;
            end
         end
         `NFCTW_CMD_SENSF: mode_d = `NFCTW_MODE_PASSIVE_HI;
         `NFCTW_CMD_ATR: mode_d = `NFCTW_MODE_ACTIVE_TGT;
         `NFCTW_CMD_TYPE_B: begin
            if (protocol_control_q[`NFCTW_CTL_CARD_EMU]) begin
               mode_d = `NFCTW_MODE_CARD_B;
            end
         end
         default: mode_d = `NFCTW_MODE_NONE;
      endcase
   end

   // Core sequential state
   always @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_q <= ST_OFF;
         forced_en_q <= 1'b0;
         osc_flag_q <= 1'b0;
         protocol_control_q <= `NFCTW_RST_BYTE;
         interrupt_cause_status_q <= `NFCTW_RST_BYTE;
         first_command_protocol_info_q <= 5'h00;
         cmd_latched_q <= 1'b0;
         irq_q <= 1'b0;
         o_target_mode <= `NFCTW_MODE_NONE;
         o_cmd_to_fifo <= 1'b0;
      end else begin
         state_q <= state_d;
         o_cmd_to_fifo <= 1'b0;
         // Internal enable forced from wake until the receive-start interrupt
         if (state_d == ST_WAKING) begin
            forced_en_q <= 1'b1;
         end else if (state_d != ST_WAIT_CMD) begin
            forced_en_q <= 1'b0;
         end
         if (state_q == ST_WAKING && state_d == ST_WAIT_CMD) begin
            osc_flag_q <= 1'b1;
         end else if (!osc_ok) begin
            osc_flag_q <= 1'b0;
         end
         if (wr_en && wr_idx == `NFCTW_IDX_PROTOCOL_CONTROL) begin
            protocol_control_q <= wr_data;
         end
         // New events win over a clear in the same cycle
         if (clr_status) begin
            interrupt_cause_status_q <= irq_set;
            irq_q <= irq_fire;
         end else begin
            interrupt_cause_status_q <= interrupt_cause_status_q | irq_set;
            irq_q <= irq_q | irq_fire;
         end
         // Protocol info: latched once per wake, low bits clear on read
         if (!(chip_en || forced_en_q)) begin
            first_command_protocol_info_q <= 5'h00;
            cmd_latched_q <= 1'b0;
            o_target_mode <= `NFCTW_MODE_NONE;
         end else if (i_first_cmd_valid && !cmd_latched_q) begin
            first_command_protocol_info_q <= proto_d;
            cmd_latched_q <= 1'b1;
            o_target_mode <= mode_d;
            o_cmd_to_fifo <= (mode_d == `NFCTW_MODE_SDD_HOST);
         end else if (rd_en && rd_idx == `NFCTW_IDX_PROTOCOL_INFO) begin
            first_command_protocol_info_q <= 5'h00;
         end
         if (state_d == ST_ABORTED) begin
            o_target_mode <= `NFCTW_MODE_NONE;
         end
      end
   end

   // Front-end control outputs, all registered
   always @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_supply_on <= 1'b0;
         o_internal_enable <= 1'b0;
         o_rf_detect_enable <= 1'b0;
         o_wake_threshold_mv <= 11'h000;
         o_clock_extractor_enable <= 1'b0;
         o_auto_sdd_enable <= 1'b0;
         o_id_size <= 2'h0;
         o_irq <= 1'b0;
      end else begin
         o_supply_on <= hold_en || chip_en || forced_en_q;
         o_internal_enable <= chip_en || forced_en_q;
         o_rf_detect_enable <= |target_wake_level_config_q[2:0];
         o_wake_threshold_mv <= threshold(target_wake_level_config_q[`NFCTW_EXT_RANGE],
            target_wake_level_config_q[2:0]);
         o_clock_extractor_enable <= (o_target_mode == `NFCTW_MODE_SDD_AUTO) ||
            (o_target_mode == `NFCTW_MODE_SDD_HOST) ||
            (o_target_mode == `NFCTW_MODE_CARD_A);
         o_auto_sdd_enable <= (o_target_mode == `NFCTW_MODE_SDD_AUTO);
         o_id_size <= {target_wake_level_config_q[`NFCTW_ID_SIZE_HI],
            target_wake_level_config_q[`NFCTW_ID_SIZE_LO]};
         o_irq <= irq_q;   // Dropped when the status clears
      end
   end
endmodule

// ### core/nfctw_map.vh
/*
 Register indices, field positions, reset values, mode codes and threshold tables
 for the NFC target wake-up and protocol detect block.
 Assumes inclusion by bare name from every design file that needs it.
*/
`ifndef NFCTW_MAP_VH
`define NFCTW_MAP_VH

// Register indices; byte address is four times the index
`define NFCTW_IDX_PROTOCOL_CONTROL 6'h01
`define NFCTW_IDX_IRQ_STATUS 6'h0C
`define NFCTW_IDX_POWER_STATUS 6'h0F
`define NFCTW_IDX_WAKE_CONFIG 6'h18
`define NFCTW_IDX_PROTOCOL_INFO 6'h19

// Reset values
`define NFCTW_RST_BYTE 8'h00

// Protocol control fields
`define NFCTW_CTL_CARD_EMU 0
`define NFCTW_CTL_NO_RX_CRC 7

// Wake level config fields
`define NFCTW_WAKE_CODE_LSB 0
`define NFCTW_WAKE_CODE_MSB 2
`define NFCTW_EXT_RANGE 3
`define NFCTW_AUTO_SDD 5
`define NFCTW_ID_SIZE_LO 6
`define NFCTW_ID_SIZE_HI 7

// Interrupt cause status bits
`define NFCTW_IRQ_TX 7
`define NFCTW_IRQ_RX_START 6
`define NFCTW_IRQ_FIFO 5
`define NFCTW_IRQ_CRC 4
`define NFCTW_IRQ_PARITY 3
`define NFCTW_IRQ_FIELD 2
`define NFCTW_IRQ_FRAMING 2
`define NFCTW_IRQ_COLLISION 1
`define NFCTW_IRQ_NO_RESP 0

// Protocol info bits
`define NFCTW_PI_WAKE_CMP 7
`define NFCTW_PI_COLL_CMP 6
`define NFCTW_PI_HIGH_CODING 4
`define NFCTW_PI_PASSIVE_LOW 3
`define NFCTW_PI_TYPE_B 2
`define NFCTW_PI_CLR_MASK 8'h1F

// Power status bits
`define NFCTW_PS_OSC_OK 6

// First command kinds from the receive decoder
`define NFCTW_CMD_NONE 3'h0
`define NFCTW_CMD_SENS 3'h1
`define NFCTW_CMD_SENSF 3'h2
`define NFCTW_CMD_ATR 3'h3
`define NFCTW_CMD_TYPE_B 3'h4

// Dispatch modes
`define NFCTW_MODE_NONE 3'h0
`define NFCTW_MODE_SDD_AUTO 3'h1
`define NFCTW_MODE_SDD_HOST 3'h2
`define NFCTW_MODE_CARD_A 3'h3
`define NFCTW_MODE_CARD_B 3'h4
`define NFCTW_MODE_PASSIVE_HI 3'h5
`define NFCTW_MODE_ACTIVE_TGT 3'h6

// Wake thresholds in mV peak-to-peak, normal range then extended range
`define NFCTW_THR_LO_1 11'h1E0
`define NFCTW_THR_LO_2 11'h15E
`define NFCTW_THR_LO_3 11'h0FA
`define NFCTW_THR_LO_4 11'h0DC
`define NFCTW_THR_LO_5 11'h0BE
`define NFCTW_THR_LO_6 11'h0B4
`define NFCTW_THR_LO_7 11'h0AA
`define NFCTW_THR_HI_1 11'h5DC
`define NFCTW_THR_HI_2 11'h2BC
`define NFCTW_THR_HI_3 11'h1F4
`define NFCTW_THR_HI_4 11'h1C2
`define NFCTW_THR_HI_5 11'h190
`define NFCTW_THR_HI_6 11'h140
`define NFCTW_THR_HI_7 11'h118

// AXI responses
`define NFCTW_RESP_OKAY 2'h0
`define NFCTW_RESP_SLVERR 2'h2

`endif

// ### core/nfctw_sync.v
/*
 Two-flop level synchroniser for pins and analog comparator outputs.
 Assumes inputs are levels held far longer than one clock period.
*/
`timescale 1ns/1ps
module nfctw_sync #(
   parameter W = 1
) (
   // Clock and reset
   input wire i_ref_clk,
   input wire i_arst_n,
   // Levels
   input wire [W-1:0] i_async,
   output wire [W-1:0] o_sync
);
   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;

   // First stage feeds only the second stage
   always @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         meta_q <= {W{1'b0}};
         sync_q <= {W{1'b0}};
      end else begin
         meta_q <= i_async;
         sync_q <= meta_q;
      end
   end

   assign o_sync = sync_q;
endmodule

// ### verif/nfctw_core_bench.sv
/* Bench for nfctw_core: AXI4-Lite tasks, wake, classify and abort runs.
 Assumes the initiator model and the map header. */
`timescale 1ns/1ps
`include "nfctw_map.vh"
module nfctw_core_bench;
   logic i_ref_clk='0, i_arst_n='0, i_vext_arst_n='0, i_supply_hold_enable='0, snd='0;
   logic i_chip_enable='0, i_wake_level_comparator='0, i_collision_level_comparator='0;
   logic i_osc_stable='0, i_awvalid='0, i_wvalid='0, i_bready='0, i_arvalid='0, i_rready='0;
   logic i_tx_done='0, i_rx_done='0;
   logic [1:0] r;
   logic [7:0] i_awaddr='0, i_araddr='0, ev='0;
   logic [31:0] i_wdata='0;
   logic [3:0] i_wstrb=4'hF;
   int n_errors=0, check_count=0, cyc=0;
   wire o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_supply_on, o_internal_enable, pv;
   wire o_rf_detect_enable, o_clock_extractor_enable, o_auto_sdd_enable, o_cmd_to_fifo, o_irq, ph;
   wire [1:0] o_bresp, o_rresp, o_id_size, pr;
   wire [2:0] o_target_mode, pk;
   wire [31:0] o_rdata;
   wire [10:0] o_wake_threshold_mv;
   always #5 i_ref_clk = ~i_ref_clk;
   // Remote initiator sends a 106 kbps wake request
   nfctw_initiator u_nfctw_initiator (.i_ref_clk, .i_send(snd), .i_kind(`NFCTW_CMD_SENS),
      .i_rate(2'h1), .o_valid(pv), .o_kind(pk), .o_high(ph), .o_rate(pr));
   nfctw_core u_nfctw_core (.*, .i_first_cmd_valid(pv), .i_first_cmd_kind(pk),
      .i_first_cmd_high_coding(ph), .i_first_cmd_rate(pr), .i_tx_start(ev[7]), .i_rx_sof(ev[6]),
      .i_fifo_level(ev[5]), .i_crc_error(ev[4]), .i_parity_error(ev[3]),
      .i_framing_error(ev[2]), .i_collision(ev[1]), .i_no_response(ev[0]));
   task chk(input logic [31:0] s, input logic [31:0] e);
      check_count++;
      n_errors += (s !== e);
      if (s !== e) $display("ERROR %0t: got %h want %h", $time, s, e);
   endtask
   task end_sim;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Address and data go up together; each drops at its own handshake
   task wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge i_ref_clk);
      i_awaddr <= a;
      i_wdata <= {24'h00_0000, v};
      i_awvalid <= 1'b1;
      i_wvalid <= 1'b1;
      i_bready <= 1'b1;
      do begin
         @(posedge i_ref_clk);
         if (o_awready) i_awvalid <= 1'b0;
         if (o_wready) i_wvalid <= 1'b0;
      end while (o_bvalid !== 1'b1);
      r = o_bresp;
      i_bready <= 1'b0;
   endtask
   task rc(input logic [7:0] a, input logic [31:0] e);
      @(posedge i_ref_clk);
      i_araddr <= a;
      i_arvalid <= 1'b1;
      do @(posedge i_ref_clk); while (o_arready !== 1'b1);
      i_arvalid <= 1'b0;
      i_rready <= 1'b1;
      do @(posedge i_ref_clk); while (o_rvalid !== 1'b1);
      chk(o_rdata, e);
      i_rready <= 1'b0;
   endtask
   task wi;
      for (int k = 0; k < 60 && o_irq !== 1'b1; k++) @(posedge i_ref_clk);
      chk(o_irq, 1'b1);
   endtask
   initial begin
      repeat (8) @(posedge i_ref_clk);
      i_arst_n <= 1'b1;
      i_vext_arst_n <= 1'b1;
      rc(8'h30, 32'h0000_0000);
      rc(8'h64, 32'h0000_0000);
      wr(8'h60, 8'hDB);
      rc(8'h60, 32'h0000_00CB);
      chk(o_wake_threshold_mv, 11'h1F4);
      chk(o_id_size, 2'h3);
      wr(8'h08, 8'h00);
      chk(r, `NFCTW_RESP_SLVERR);
      wr(8'h60, 8'h01);
      rc(8'h60, 32'h0000_0001);
      chk(o_wake_threshold_mv, 11'h1E0);
      $display("config test done");
      i_wake_level_comparator <= 1'b1;
      i_collision_level_comparator <= 1'b1;
      repeat (8) @(posedge i_ref_clk);
      chk(o_internal_enable, 1'b1);
      i_osc_stable <= 1'b1;
      wi;
      rc(8'h30, 32'h0000_0004);
      i_chip_enable <= 1'b1;
      snd <= 1'b1;
      @(posedge i_ref_clk);
      snd <= 1'b0;
      wi;
      rc(8'h30, 32'h0000_0040);
      chk(o_target_mode, `NFCTW_MODE_SDD_HOST);
      chk(o_clock_extractor_enable, 1'b1);
      chk(o_auto_sdd_enable, 1'b0);
      rc(8'h64, 32'h0000_00C9);
      rc(8'h64, 32'h0000_00C0);
      for (int i = 0; i < 8; i++) begin
         ev <= 8'h01 << i;
         @(posedge i_ref_clk);
         ev <= 8'h00;
         rc(8'h30, 32'h0000_0001 << i);
      end
      $display("wake test done");
      i_collision_level_comparator <= 1'b0;
      i_wake_level_comparator <= 1'b0;
      wi;
      rc(8'h30, 32'h0000_0004);
      {i_tx_done, ev} <= 9'h180;
      @(posedge i_ref_clk);
      {i_tx_done, ev} <= 9'h000;
      wi;
      wr(8'h04, 8'h00);
      rc(8'h30, 32'h0000_0000);
      chk(o_irq, 1'b0);
      i_chip_enable <= 1'b0;
      i_supply_hold_enable <= 1'b1;
      repeat (8) @(posedge i_ref_clk);
      chk(o_supply_on, 1'b1);
      rc(8'h64, 32'h0000_0000);
      rc(8'h60, 32'h0000_0001);
      $display("abort test done");
      end_sim;
   end
   // Ceiling far above the roughly 150 cycles the run needs
   always @(posedge i_ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_errors++;
         end_sim;
      end
   end
endmodule
bind nfctw_core nfctw_monitor u_nfctw_monitor (.*);

// ### verif/nfctw_initiator.sv
/* Initiator model: presents one decoded first command for one clock.
 Assumes i_send is a one-clock pulse. */
`timescale 1ns/1ps
module nfctw_initiator (
   input wire i_ref_clk, input wire i_send, input wire [2:0] i_kind, input wire [1:0] i_rate,
   output logic o_valid = 1'b0, output logic [2:0] o_kind = 3'h0, output logic o_high = 1'b0,
   output logic [1:0] o_rate = 2'h0
);
   // Released fields flip each cycle so stale values never pass for valid
   always @(posedge i_ref_clk) begin
      o_valid <= i_send;
      o_kind <= i_send ? i_kind : ~o_kind;
      o_high <= i_send ? i_rate != 2'h1 : ~o_high;
      o_rate <= i_send ? i_rate : ~o_rate;
   end
endmodule

// ### verif/nfctw_monitor.sv
/* Checker on nfctw_core ports.
 Assumes a bind from the bench and a single clock domain. */
`timescale 1ns/1ps
`include "nfctw_map.vh"
module nfctw_monitor (
   // Watched ports
   input wire i_ref_clk, input wire i_arst_n, input wire i_supply_hold_enable,
   input wire i_tx_done, input wire o_supply_on, input wire o_rf_detect_enable,
   input wire [10:0] o_wake_threshold_mv, input wire o_irq, input wire o_cmd_to_fifo,
   input wire [2:0] o_target_mode, input wire o_internal_enable, input wire o_rvalid,
   input wire [31:0] o_rdata, input wire o_bvalid, input wire i_bready, input wire o_awready
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_arst_n);
   // Two sync flops plus the output flop make the pin three cycles late
   sequence s_hold; i_supply_hold_enable [*4]; endsequence
   supply_hold_a: assert property (s_hold |-> o_supply_on) else $error("supply");
   wake_thr_a: assert property (
      o_rf_detect_enable == (o_wake_threshold_mv != 11'h000)) else $error("thr");
   tx_irq_a: assert property (
      i_tx_done && o_internal_enable |-> ##[1:3] o_irq) else $error("tx irq");
   to_fifo_a: assert property (
      o_cmd_to_fifo |-> ##[0:1] o_target_mode == `NFCTW_MODE_SDD_HOST) else $error("fifo");
   irq_drop_a: assert property (!o_internal_enable [*3] |-> !o_irq) else $error("irq");
   rdata_top_a: assert property (o_rvalid |-> o_rdata[31:8] == 24'h00_0000) else $error("rd");
   b_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid) else $error("bvalid");
   aw_block_a: assert property (o_bvalid |-> !o_awready) else $error("awready");
endmodule
